// ---- pkg/spmux_fdc_if.sv ----
/*
  spmux_fdc_if: carries floppy controller signals and the resulting connector
  drive between the top module and the floppy pin mapper.
  Assumes: all members live in the ref_clk domain.
*/
`timescale 1ns/100ps
interface spmux_fdc_if;
  // asserted-high outputs of the floppy controller, then swap/dual controls and the mapped pin enables
  logic drive_select0_out;
  logic drive_select1_out;
  logic motor_on0_out;
  logic motor_on1_out;
  logic write_stream_out;
  logic write_enable_gate_out;
  logic density_select_out;
  logic head_side_select_out;
  logic step_direction_out;
  logic head_step_out;
  logic drive_swap_bit;
  logic dual_drive;
  logic [16:0] od_oe;

  modport top (
    output drive_select0_out, drive_select1_out, motor_on0_out, motor_on1_out,
    output write_stream_out, write_enable_gate_out, density_select_out,
    output head_side_select_out, step_direction_out, head_step_out,
    output drive_swap_bit, dual_drive,
    input od_oe
  );
  modport mapper (
    input drive_select0_out, drive_select1_out, motor_on0_out, motor_on1_out,
    input write_stream_out, write_enable_gate_out, density_select_out,
    input head_side_select_out, step_direction_out, head_step_out,
    input drive_swap_bit, dual_drive,
    output od_oe
  );
endinterface : spmux_fdc_if

// ---- pkg/spmux_pkg.sv ----
/*
  spmux_pkg: shared constants for the shared parallel pin owner mux.
  Pin index map, register offsets, field positions, reset values and owner codes.
  Assumes: an 8-bit register port and one 200 MHz clock domain.
*/
package spmux_pkg;
  // ==========================================================
  // pin index map on the connector vector
  localparam int SPMUX_NPINS = 17;
  localparam int PIN_D0 = 0;
  localparam int PIN_D6 = 6;
  localparam int PIN_STROBE = 8;
  localparam int PIN_ACK = 9;
  localparam int PIN_BUSY = 10;
  localparam int PIN_PE = 11;
  localparam int PIN_SELECTED_STATUS_LINE = 12;
  localparam int PIN_ALF = 13;
  localparam int PIN_ERR = 14;
  localparam int PIN_INIT = 15;
  localparam int PIN_SLCTIN = 16;

  // ==========================================================
  // register offsets
  localparam logic [7:0] REG_MODE = 8'h25;
  localparam logic [7:0] REG_OWNER = 8'h30;
  localparam logic [7:0] REG_MICRO_DISABLE = 8'h31;
  localparam logic [7:0] REG_UC_DATA = 8'h32;
  localparam logic [7:0] REG_UC_CTRL = 8'h33;
  localparam logic [7:0] REG_PIN_DATA = 8'h34;
  localparam logic [7:0] REG_PIN_STAT = 8'h35;
  localparam logic [7:0] REG_STATE = 8'h36;

  // ==========================================================
  // field positions
  localparam int MODE_LSB = 3;
  localparam int OWN_HOST_BIT = 0;
  localparam int OWN_FDC_ACT_BIT = 1;
  localparam int OWN_FDC_PD_BIT = 2;
  localparam int OWN_PP_ACT_BIT = 3;
  localparam int OWN_PP_PD_BIT = 4;
  localparam int OWN_SWAP_BIT = 5;
  localparam int PORT_EN_BIT = 7;
  localparam int UC_DIR_BIT = 4;
  localparam int STAT_CABLE_LVL_BIT = 5;
  localparam int STAT_CABLE_CHG_BIT = 6;
  localparam int STAT_AUX_BIT = 7;

  // ==========================================================
  // reset values
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [5:0] OWNER_RST = 6'h00;
  localparam logic PORT_EN_RST = 1'b0;
  localparam logic [7:0] UC_DATA_RST = 8'h00;
  localparam logic [4:0] UC_CTRL_RST = 5'h00;

  // ==========================================================
  // device mode field encodings
  localparam logic [1:0] MODE_HOST = 2'h0;
  localparam logic [1:0] MODE_SINGLE = 2'h1;
  localparam logic [1:0] MODE_DUAL = 2'h2;

  // host view of control/status while the host does not own the pins
  localparam logic [7:0] HOST_CTRL_UNOWNED = 8'h04;
  localparam logic [7:0] HOST_STAT_UNOWNED = 8'h48;

  typedef enum logic [1:0] {
    OWN_MICRO,
    OWN_FDC,
    OWN_HOST,
    OWN_NONE
  } spmux_owner_t;
endpackage : spmux_pkg

// ---- testbench/shared_parallel_pin_owner_mux_test.sv ----
/*
  shared_parallel_pin_owner_mux_test: directed bench for spmux_top.
  Assumes: register offsets and codes from spmux_pkg, 200 MHz ref_clk.
*/
`timescale 1ns/100ps
module shared_parallel_pin_owner_mux_test
  import spmux_pkg::*;
;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [16:0] pin_in, pin_out, pin_oe, pp_pin_in;
  logic aux = 1'b1;
  logic cable = 1'b0;
  logic irq;
  logic [9:0] fl = 10'h000;
  logic [4:0] fin_n;
  logic [4:0] media = 5'h00;
  logic [16:0] pp_out = 17'h0_1234;
  logic [16:0] pp_oe = 17'h1_00F0;
  logic hwr = 1'b0;
  logic [7:0] hwd = 8'h00;
  logic [7:0] hd, hc, hs;
  int miscompares = 0;
  int total_checks = 0;
  int pulses;

  spmux_top DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .aux_supply_valid(aux), .cable_type_sense(cable), .cable_sense_irq(irq),
    .drive_select0_out(fl[0]), .motor_on0_out(fl[1]), .drive_select1_out(fl[2]), .motor_on1_out(fl[3]),
    .write_stream_out(fl[4]), .write_enable_gate_out(fl[5]), .density_select_out(fl[6]),
    .head_side_select_out(fl[7]), .step_direction_out(fl[8]), .head_step_out(fl[9]),
    .index_pulse_in_n(fin_n[0]), .track_zero_in_n(fin_n[1]), .write_protect_in_n(fin_n[2]),
    .read_stream_in_n(fin_n[3]), .disk_change_in_n(fin_n[4]), .pp_pin_out(pp_out), .pp_pin_oe(pp_oe),
    .pp_pin_in(pp_pin_in), .host_data_wr(hwr), .host_wdata(hwd), .pp_data_rd(8'h11), .pp_ctrl_rd(8'h22),
    .pp_stat_rd(8'h33), .host_data_rd(hd), .host_ctrl_rd(hc), .host_stat_rd(hs));
  spmux_drive_model u_drive (.pin_out(pin_out), .pin_oe(pin_oe), .media_stat(media), .pin_in(pin_in));

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(n, {9'h000, e}, {9'h000, reg_rdata});
  endtask : rd

  task automatic settle;
    repeat (5) @(posedge ref_clk);
    #1;
  endtask : settle

  // expected connector enable for floppy output i (order of fl)
  function automatic logic [16:0] fdc_pin(input logic dl, input logic sw, input logic [3:0] i);
    logic b;
    if (i > 4'd3) return 17'h0_0001 << ({1'b0, i} + 5'd7);
    if (!dl && (i[1] == sw)) return 17'h0_0000;
    b = dl ? (i[1] ^ sw) : i[1];
    return 17'h0_0001 << (b ? (i[0] ? 10 : 9) : (i[0] ? 6 : 8));
  endfunction : fdc_pin

  task automatic finish_test;
    if (miscompares == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    finish_test;
  end

  initial begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    wr(REG_UC_DATA, 8'hA5);
    wr(REG_UC_CTRL, 8'h05);
    wr(REG_MODE, 8'h08);
    settle;
    chk("micro oe", 17'h1_A1FF, pin_oe);
    chk("micro out", 17'h0_81A5, pin_out & pin_oe);
    wr(REG_UC_CTRL, 8'h15);
    settle;
    chk("micro input oe", 17'h1_A100, pin_oe);
    rd("pin data", REG_PIN_DATA, 8'hFF);
    aux <= 1'b0;
    settle;
    chk("no supply oe", 17'h0_0000, pin_oe);
    aux <= 1'b1;
    hwd <= 8'h3C;
    hwr <= 1'b1;
    @(posedge ref_clk);
    hwr <= 1'b0;
    settle;
    chk("unowned data", 17'h0_003C, {9'h000, hd});
    chk("unowned ctrl", 17'h0_0004, {9'h000, hc});
    chk("unowned stat", 17'h0_0048, {9'h000, hs});
    wr(REG_MICRO_DISABLE, 8'h80);
    wr(REG_MODE, 8'h00);
    wr(REG_OWNER, 8'h09);
    settle;
    chk("host oe", pp_oe, pin_oe);
    chk("owned stat", 17'h0_0033, {9'h000, hs});
    chk("host out", pp_out & pp_oe, pin_out & pin_oe);
    chk("host pin view", pin_in, pp_pin_in);
    chk("owned ctrl", 17'h0_0022, {9'h000, hc});
    chk("owned data", 17'h0_0011, {9'h000, hd});
    wr(REG_MICRO_DISABLE, 8'h00);
    settle;
    chk("port disabled oe", 17'h0_0000, pin_oe);
    wr(REG_MICRO_DISABLE, 8'h80);
    wr(REG_OWNER, 8'h19);
    settle;
    chk("host powerdown oe", 17'h0_0000, pin_oe);
    wr(REG_OWNER, 8'h01);
    settle;
    chk("host inactive oe", 17'h0_0000, pin_oe);
    wr(REG_OWNER, 8'h09);
    wr(REG_MODE, 8'h18);
    settle;
    chk("no owner oe", 17'h0_0000, pin_oe);
    for (int c = 0; c < 4; c++) begin
      wr(REG_MODE, c[1] ? 8'h10 : 8'h08);
      wr(REG_OWNER, {2'b00, c[0], 5'h03});
      rd("mode field", REG_MODE, c[1] ? 8'h10 : 8'h08);
      for (int i = 0; i < 10; i++) begin
        fl <= 10'h001 << i;
        settle;
        chk("floppy oe", fdc_pin(c[1], c[0], 4'(i)), pin_oe);
        chk("floppy out", 17'h0_0000, pin_out);
      end
    end
    wr(REG_MICRO_DISABLE, 8'h00);
    settle;
    chk("floppy port disabled oe", 17'h1_0000, pin_oe);
    rd("owner state", REG_STATE, 8'h05);
    media <= 5'b10110;
    settle;
    chk("floppy inputs", 17'h0_0009, {12'h000, fin_n});
    wr(REG_OWNER, 8'h07);
    settle;
    chk("floppy powerdown oe", 17'h0_0000, pin_oe);
    wr(REG_OWNER, 8'h01);
    settle;
    chk("floppy inactive oe", 17'h0_0000, pin_oe);
    wr(REG_OWNER, 8'h00);
    settle;
    chk("micro floppy inputs", 17'h0_001F, {12'h000, fin_n});
    rd("unmapped", 8'h7F, 8'h00);
    for (int k = 0; k < 2; k++) begin
      @(posedge ref_clk) cable <= ~cable;
      pulses = 0;
      repeat (10) @(posedge ref_clk) #1 pulses += int'(irq);
      chk("irq count", 17'h0_0001, 17'(pulses));
    end
    finish_test;
  end
endmodule : shared_parallel_pin_owner_mux_test

// ---- testbench/spmux_drive_model.sv ----
/*
  spmux_drive_model: floppy drive on the connector with pull-ups on every line.
  Assumes: lines resolve as wired-and of the mux drive and the drive's sinks.
*/
`timescale 1ns/100ps
module spmux_drive_model (
  input wire logic [16:0] pin_out,
  input wire logic [16:0] pin_oe,
  input wire logic [4:0] media_stat,
  output logic [16:0] pin_in
);
  // released lines float high
  // drive status lines sink data 0..4 low while asserted
  assign pin_in = (pin_out | ~pin_oe) & ~{12'h000, media_stat};
endmodule : spmux_drive_model

// ---- testbench/spmux_props.sv ----
/*
  spmux_props: port-level assertions for spmux_top.
  Assumes: bound to spmux_top, single ref_clk domain, sync reset.
*/
`timescale 1ns/100ps
module spmux_props
  import spmux_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [16:0] pin_in,
  input wire logic [16:0] pin_oe,
  input wire logic aux_supply_valid,
  input wire logic cable_type_sense,
  input wire logic cable_sense_irq,
  input wire logic index_pulse_in_n,
  input wire logic track_zero_in_n,
  input wire logic write_protect_in_n,
  input wire logic read_stream_in_n,
  input wire logic disk_change_in_n,
  input wire logic [16:0] pp_pin_in,
  input wire logic [7:0] pp_ctrl_rd,
  input wire logic [7:0] pp_stat_rd,
  input wire logic [7:0] host_ctrl_rd,
  input wire logic [7:0] host_stat_rd
);
  logic [4:0] fl_in_n;
  assign fl_in_n = {disk_change_in_n, read_stream_in_n, write_protect_in_n, track_zero_in_n, index_pulse_in_n};
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // pins and register port
  chk_supply_release: assert property (!aux_supply_valid [*4] |-> pin_oe == 17'h0_0000)
    else $error("pins driven without secondary supply");
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  chk_mode_read: assert property (reg_rd && reg_addr == REG_MODE |=> (reg_rdata & 8'hE7) == 8'h00)
    else $error("mode register stray bits");
  // ==========================================================
  // cable sense interrupt
  chk_irq_cause: assert property (cable_type_sense != $past(cable_type_sense) |-> ##[3:5] cable_sense_irq)
    else $error("cable change without interrupt");
  chk_irq_pulse: assert property (cable_sense_irq |=> !cable_sense_irq)
    else $error("interrupt longer than one cycle");
  // ==========================================================
  // routed inputs and host view
  chk_floppy_inputs: assert property ((~fl_in_n & $past(pin_in[4:0], 3)) == 5'h00)
    else $error("floppy input low without pin low");
  chk_host_pins: assert property (pp_pin_in != 17'h1_FFFF |-> pp_pin_in == $past(pin_in, 3))
    else $error("host pin view not from pins");
  chk_ctrl_view: assert property (host_ctrl_rd != $past(pp_ctrl_rd) |-> host_ctrl_rd == HOST_CTRL_UNOWNED)
    else $error("unowned control read wrong");
  chk_stat_view: assert property (host_stat_rd != $past(pp_stat_rd) |-> host_stat_rd == HOST_STAT_UNOWNED)
    else $error("unowned status read wrong");
endmodule : spmux_props

bind spmux_top spmux_props u_props (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .pin_in(pin_in), .pin_oe(pin_oe), .aux_supply_valid(aux_supply_valid),
  .cable_type_sense(cable_type_sense), .cable_sense_irq(cable_sense_irq), .index_pulse_in_n(index_pulse_in_n),
  .track_zero_in_n(track_zero_in_n), .write_protect_in_n(write_protect_in_n), .read_stream_in_n(read_stream_in_n),
  .disk_change_in_n(disk_change_in_n), .pp_pin_in(pp_pin_in), .pp_ctrl_rd(pp_ctrl_rd), .pp_stat_rd(pp_stat_rd),
  .host_ctrl_rd(host_ctrl_rd), .host_stat_rd(host_stat_rd));

// ---- verilog/spmux_fdc_map.sv ----
/*
  spmux_fdc_map: maps floppy controller outputs onto connector pins as
  open-drain pull-downs, with single/dual drive and drive swap.
  Assumes: the caller registers the result and gates it by ownership.
*/
`timescale 1ns/100ps
module spmux_fdc_map
  import spmux_pkg::*;
(
  spmux_fdc_if.mapper fdc
);
  logic pair0_en;
  logic pair1_en;
  logic sel_a;
  logic sel_b;
  logic mtr_a;
  logic mtr_b;
  logic xchg;

  // ==========================================================
  // drive pair placement
  // swap exchanges drives
  // single mode: swap only picks the live pair, each drive keeps its own pins
  assign xchg = fdc.drive_swap_bit & fdc.dual_drive;
  assign sel_a = xchg ? fdc.drive_select1_out : fdc.drive_select0_out;
  assign sel_b = xchg ? fdc.drive_select0_out : fdc.drive_select1_out;
  assign mtr_a = xchg ? fdc.motor_on1_out : fdc.motor_on0_out;
  assign mtr_b = xchg ? fdc.motor_on0_out : fdc.motor_on1_out;
  assign pair0_en = fdc.dual_drive | fdc.drive_swap_bit;
  assign pair1_en = fdc.dual_drive | ~fdc.drive_swap_bit;

  // ==========================================================
  // open-drain: enable pulls low only while the signal is asserted
  always_comb begin
    fdc.od_oe = '0;
    fdc.od_oe[PIN_STROBE] = pair0_en & sel_a;
    fdc.od_oe[PIN_D6] = pair0_en & mtr_a;
    fdc.od_oe[PIN_ACK] = pair1_en & sel_b;
    fdc.od_oe[PIN_BUSY] = pair1_en & mtr_b;
    fdc.od_oe[PIN_PE] = fdc.write_stream_out;
    fdc.od_oe[PIN_SELECTED_STATUS_LINE] = fdc.write_enable_gate_out;
    fdc.od_oe[PIN_ALF] = fdc.density_select_out;
    fdc.od_oe[PIN_ERR] = fdc.head_side_select_out;
    fdc.od_oe[PIN_INIT] = fdc.step_direction_out;
    fdc.od_oe[PIN_SLCTIN] = fdc.head_step_out;
  end
endmodule : spmux_fdc_map

// ---- verilog/spmux_top.sv ----
/*
  spmux_top: owner mux for the shared parallel connector pins.
  Chooses micro, floppy or host parallel logic per mode field and host flag,
  drives 17 pins as in/out/oe, shapes host read-back while unowned.
  Assumes: pins and supply/cable inputs are asynchronous; everything else,
  including the register port and the floppy and parallel logic, is on ref_clk.
*/
// The register offsets and strobed register access were decided locally.
`timescale 1ns/100ps
module spmux_top
  import spmux_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // connector pins
  input wire logic [16:0] pin_in,
  output logic [16:0] pin_out,
  output logic [16:0] pin_oe,
  input wire logic aux_supply_valid,
  input wire logic cable_type_sense,
  output logic cable_sense_irq,
  // floppy controller, outputs asserted high, status inputs active low
  input wire logic drive_select0_out,
  input wire logic drive_select1_out,
  input wire logic motor_on0_out,
  input wire logic motor_on1_out,
  input wire logic write_stream_out,
  input wire logic write_enable_gate_out,
  input wire logic density_select_out,
  input wire logic head_side_select_out,
  input wire logic step_direction_out,
  input wire logic head_step_out,
  output logic index_pulse_in_n,
  output logic track_zero_in_n,
  output logic write_protect_in_n,
  output logic read_stream_in_n,
  output logic disk_change_in_n,
  // legacy parallel logical device
  input wire logic [16:0] pp_pin_out,
  input wire logic [16:0] pp_pin_oe,
  output logic [16:0] pp_pin_in,
  input wire logic host_data_wr,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] pp_data_rd,
  input wire logic [7:0] pp_ctrl_rd,
  input wire logic [7:0] pp_stat_rd,
  output logic [7:0] host_data_rd,
  output logic [7:0] host_ctrl_rd,
  output logic [7:0] host_stat_rd
);
  // ==========================================================
  // synchronisers
  logic [16:0] pin_s1_reg;
  logic [16:0] pin_s2_reg;
  logic [1:0] aux_s_reg;
  logic [1:0] cable_s_reg;
  logic cable_d_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_s1_reg <= '1;
      pin_s2_reg <= '1;
      aux_s_reg <= 2'h0;
      cable_s_reg <= 2'h0;
      cable_d_reg <= 1'b0;
    end else begin
      pin_s1_reg <= pin_in;
      pin_s2_reg <= pin_s1_reg;
      aux_s_reg <= {aux_s_reg[0], aux_supply_valid};
      cable_s_reg <= {cable_s_reg[0], cable_type_sense};
      cable_d_reg <= cable_s_reg[1];
    end
  end

  // ==========================================================
  // configuration registers
  logic [1:0] mode_reg;
  logic [5:0] owner_cfg_reg;
  logic port_en_reg;
  logic [7:0] uc_data_reg;
  logic [4:0] uc_ctrl_reg;
  logic cable_chg_reg;
  logic cable_edge;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mode_reg <= MODE_RST;
      owner_cfg_reg <= OWNER_RST;
      port_en_reg <= PORT_EN_RST;
      uc_data_reg <= UC_DATA_RST;
      uc_ctrl_reg <= UC_CTRL_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        REG_MODE: mode_reg <= reg_wdata[MODE_LSB +: 2];
        REG_OWNER: owner_cfg_reg <= reg_wdata[5:0];
        REG_MICRO_DISABLE: port_en_reg <= reg_wdata[PORT_EN_BIT];
        REG_UC_DATA: uc_data_reg <= reg_wdata;
        REG_UC_CTRL: uc_ctrl_reg <= reg_wdata[4:0];
        default: ;
      endcase
    end
  end

  assign cable_edge = cable_s_reg[1] ^ cable_d_reg;

  // sticky change flag, write one to clear; a new edge beats the clear
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cable_chg_reg <= 1'b0;
      cable_sense_irq <= 1'b0;
    end else begin
      cable_sense_irq <= cable_edge;
      if (cable_edge) begin
        cable_chg_reg <= 1'b1;
      end else if (reg_wr && reg_addr == REG_PIN_STAT && reg_wdata[STAT_CABLE_CHG_BIT]) begin
        cable_chg_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // ownership decode
  spmux_owner_t owner;
  logic host_flag;
  logic owner_live;

  assign host_flag = owner_cfg_reg[OWN_HOST_BIT];

  always_comb begin
    owner = OWN_NONE;
    if (!host_flag) begin
      owner = OWN_MICRO;
    end else if (mode_reg == MODE_SINGLE || mode_reg == MODE_DUAL) begin
      owner = OWN_FDC;
    end else if (mode_reg == MODE_HOST) begin
      owner = OWN_HOST;
    end
  end

  always_comb begin
    owner_live = 1'b0;
    unique case (owner)
      OWN_MICRO: owner_live = 1'b1;
      OWN_FDC: owner_live = owner_cfg_reg[OWN_FDC_ACT_BIT] & ~owner_cfg_reg[OWN_FDC_PD_BIT];
      OWN_HOST: owner_live = owner_cfg_reg[OWN_PP_ACT_BIT] & ~owner_cfg_reg[OWN_PP_PD_BIT] & port_en_reg;
      OWN_NONE: owner_live = 1'b0;
    endcase
  end

  // ==========================================================
  // floppy mapping
  spmux_fdc_if fdc_bus ();

  assign fdc_bus.drive_select0_out = drive_select0_out;
  assign fdc_bus.drive_select1_out = drive_select1_out;
  assign fdc_bus.motor_on0_out = motor_on0_out;
  assign fdc_bus.motor_on1_out = motor_on1_out;
  assign fdc_bus.write_stream_out = write_stream_out;
  assign fdc_bus.write_enable_gate_out = write_enable_gate_out;
  assign fdc_bus.density_select_out = density_select_out;
  assign fdc_bus.head_side_select_out = head_side_select_out;
  assign fdc_bus.step_direction_out = step_direction_out;
  assign fdc_bus.head_step_out = head_step_out;
  assign fdc_bus.drive_swap_bit = owner_cfg_reg[OWN_SWAP_BIT];
  assign fdc_bus.dual_drive = (mode_reg == MODE_DUAL);

  spmux_fdc_map u_fdc_map (
    .fdc(fdc_bus.mapper)
  );

  // ==========================================================
  // pin drive select, registered
  logic [16:0] uc_out;
  logic [16:0] uc_oe;

  always_comb begin
    uc_out = '1;
    uc_oe = '1;
    uc_out[7:0] = uc_data_reg;
    uc_oe[7:0] = {8{~uc_ctrl_reg[UC_DIR_BIT]}};
    uc_out[PIN_STROBE] = uc_ctrl_reg[0];
    uc_out[PIN_ALF] = uc_ctrl_reg[1];
    uc_out[PIN_INIT] = uc_ctrl_reg[2];
    uc_out[PIN_SLCTIN] = uc_ctrl_reg[3];
    // status lines stay inputs for the micro
    uc_oe[PIN_ACK] = 1'b0;
    uc_oe[PIN_BUSY] = 1'b0;
    uc_oe[PIN_PE] = 1'b0;
    uc_oe[PIN_SELECTED_STATUS_LINE] = 1'b0;
    uc_oe[PIN_ERR] = 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else if (!aux_s_reg[1] || !owner_live) begin
      pin_out <= '0;
      pin_oe <= '0;
    end else begin
      unique case (owner)
        OWN_MICRO: begin
          pin_out <= uc_out;
          pin_oe <= uc_oe;
        end
        OWN_FDC: begin
          pin_out <= '0;
          pin_oe <= fdc_bus.od_oe;
        end
        OWN_HOST: begin
          pin_out <= pp_pin_out;
          pin_oe <= pp_pin_oe;
        end
        OWN_NONE: begin
          pin_out <= '0;
          pin_oe <= '0;
        end
      endcase
    end
  end

  // ==========================================================
  // floppy inputs and parallel device inputs
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      index_pulse_in_n <= 1'b1;
      track_zero_in_n <= 1'b1;
      write_protect_in_n <= 1'b1;
      read_stream_in_n <= 1'b1;
      disk_change_in_n <= 1'b1;
      pp_pin_in <= '1;
    end else begin
      if (owner == OWN_FDC) begin
        index_pulse_in_n <= pin_s2_reg[PIN_D0];
        track_zero_in_n <= pin_s2_reg[PIN_D0 + 1];
        write_protect_in_n <= pin_s2_reg[PIN_D0 + 2];
        read_stream_in_n <= pin_s2_reg[PIN_D0 + 3];
        disk_change_in_n <= pin_s2_reg[PIN_D0 + 4];
      end else begin
        index_pulse_in_n <= 1'b1;
        track_zero_in_n <= 1'b1;
        write_protect_in_n <= 1'b1;
        read_stream_in_n <= 1'b1;
        disk_change_in_n <= 1'b1;
      end
      // host sees idle pins unless owner
      pp_pin_in <= (owner == OWN_HOST) ? pin_s2_reg : '1;
    end
  end

  // ==========================================================
  // host read-back of legacy registers
  logic [7:0] host_last_wr_reg;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      host_last_wr_reg <= 8'h00;
    end else if (host_data_wr) begin
      host_last_wr_reg <= host_wdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      host_data_rd <= 8'h00;
      host_ctrl_rd <= HOST_CTRL_UNOWNED;
      host_stat_rd <= HOST_STAT_UNOWNED;
    end else if (owner == OWN_HOST) begin
      host_data_rd <= pp_data_rd;
      host_ctrl_rd <= pp_ctrl_rd;
      host_stat_rd <= pp_stat_rd;
    end else begin
      host_data_rd <= host_data_wr ? host_wdata : host_last_wr_reg;
      host_ctrl_rd <= HOST_CTRL_UNOWNED;
      host_stat_rd <= HOST_STAT_UNOWNED;
    end
  end

  // ==========================================================
  // register read port, data one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        REG_MODE: reg_rdata <= {3'h0, mode_reg, 3'h0};
        REG_OWNER: reg_rdata <= {2'h0, owner_cfg_reg};
        REG_MICRO_DISABLE: reg_rdata <= {port_en_reg, 7'h00};
        REG_UC_DATA: reg_rdata <= uc_data_reg;
        REG_UC_CTRL: reg_rdata <= {3'h0, uc_ctrl_reg};
        REG_PIN_DATA: reg_rdata <= pin_s2_reg[7:0];
        REG_PIN_STAT: reg_rdata <= {aux_s_reg[1], cable_chg_reg, cable_s_reg[1],
                                    pin_s2_reg[PIN_ERR], pin_s2_reg[PIN_SELECTED_STATUS_LINE], pin_s2_reg[PIN_PE],
                                    pin_s2_reg[PIN_BUSY], pin_s2_reg[PIN_ACK]};
        REG_STATE: reg_rdata <= {5'h00, owner_live, owner};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule : spmux_top
